// ==== hw/cvs_core.sv ====
// Function
// - startup target from boot code pins
// - after boot, select cpu or suspend code
// - suspend code from three four-level pins
// - suspend select overrides cpu code
// - force pwm on suspend moves until 63 ticks after landing
// - follow cpu code changes while not suspended
// - freeze power-good, clock-enable during transitions
// - release freeze 32 ticks after landing
// - step one 16 mV code per tick
// - rising takes one tick per step
// - falling adds two ticks
// - overvoltage: power-good low, clock-enable high
// - overvoltage latches low-side drive high
// - undervoltage latches pwm off
// - undervoltage blanked during and 32 after
// - thermal: low-side high, high-side low
// - test mode bypasses and clears faults
// - test mode from high-voltage shutdown detect
// - 50 us after boot ok, enable clocks
// - power-good waits 3 ms after clock enable
`default_nettype none
module cvs_core
    import cvs_pkg::*;
#(
    parameter int SYSOK_CYC = SYSOK_DLY_CYC,
    parameter int PGOOD_CYC = PGOOD_DLY_CYC
) (
    input  wire logic                sys_clk_i,
    input  wire logic                nrst_i,
    input  wire logic                shutdown_n_i,
    input  wire logic                test_hv_i,
    input  wire logic                slew_tick_i,
    input  wire logic [3*PIN4_W-1:0] boot_code_pins_i,
    input  wire logic [3*PIN4_W-1:0] suspend_code_pins_i,
    input  wire logic [CODE_W-1:0]   cpu_voltage_code_pins_i,
    input  wire logic                suspend_select_i,
    input  wire logic                system_power_good_in_i,
    input  wire logic                fb_at_target_i,
    input  wire cvs_fault_t          fault_det_i,
    output logic [CODE_W-1:0]        dac_code_o,
    output cvs_drive_t               drive_o,
    output logic                     core_power_good_out_o,
    output logic                     clock_gen_enable_n_o,
    output cvs_fault_t               fault_latch_o,
    output logic                     transition_o
);
    import cvs_pkg::*;

    // refuse counts that the timer or the 6-bit tick counters cannot hold
    if (SYSOK_CYC < 1 || PGOOD_CYC < 1 ||
        SYSOK_CYC >= (1 << TMR_W) ||
        PGOOD_CYC >= (1 << TMR_W)) begin : g_bad_tmr
        $error("timer counts out of range");
    end
    if (BLANK_CYC > 63 || FORCE_PWM_CYC > 63) begin : g_bad_cnt
        $error("tick counts exceed counter width");
    end

    typedef enum logic [3:0] {
        ST_BOOT  = 4'b0001,
        ST_WAIT  = 4'b0010,
        ST_CKEN  = 4'b0100,
        ST_RUN   = 4'b1000
    } cvs_state_t;

    // four-level pin decode, two bits per pin, msb pin first
    logic [CODE_W-1:0] boot_code, susp_code, target;
    // one decoder per four-level pin; levels arrive already as 2-bit codes
    logic [CODE_W-1:0] susp_raw;
    for (genvar p = 0; p < 3; p++) begin : g_pin
        assign boot_code[p*PIN4_W +: PIN4_W] =
            boot_code_pins_i[p*PIN4_W +: PIN4_W];
        assign susp_raw[p*PIN4_W +: PIN4_W] =
            suspend_code_pins_i[p*PIN4_W +: PIN4_W];
    end
    // suspend table starts lower on the scale, so offset before use
    assign susp_code = 6'(7'(susp_raw) + SUSP_CODE_OFS);

    logic              bypass;
    logic              restart;
    logic [CODE_W-1:0] code;
    logic              moving, landed;

    cvs_state_t        st_r, st_nxt;
    logic [TMR_W-1:0]  tmr_r, tmr_nxt;
    logic [5:0]        blank_r, blank_nxt;
    logic [5:0]        fpwm_r, fpwm_nxt;
    logic              susp_mv_r, susp_mv_nxt;
    cvs_fault_t        flt_r, flt_nxt;
    logic              pg_r, pg_nxt;
    logic              cken_n_r, cken_n_nxt;
    cvs_drive_t        drv_r, drv_nxt;
    logic [CODE_W-1:0] dac_r;
    logic              tr_r;

    assign bypass  = test_hv_i;
    assign restart = !shutdown_n_i;

    always_comb begin
        if (st_r == ST_BOOT || st_r == ST_WAIT) begin
            target = boot_code;
        end else if (suspend_select_i) begin
            target = susp_code;
        end else begin
            target = cpu_voltage_code_pins_i;
        end
    end

    cvs_slew u_slew (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .restart_i   (restart),
        .slew_tick_i (slew_tick_i),
        .target_i    (target),
        .code_o      (code),
        .moving_o    (moving),
        .landed_o    (landed)
    );

    logic blanked;
    assign blanked = moving || (blank_r != 6'h00);

    always_comb begin
        st_nxt      = st_r;
        tmr_nxt     = tmr_r;
        blank_nxt   = blank_r;
        fpwm_nxt    = fpwm_r;
        susp_mv_nxt = susp_mv_r;
        flt_nxt     = flt_r;
        pg_nxt      = pg_r;
        cken_n_nxt  = cken_n_r;

        // post-landing counters count slew ticks
        if (moving) begin
            blank_nxt = 6'(BLANK_CYC);
            if (suspend_select_i) begin
                susp_mv_nxt = 1'b1;
                fpwm_nxt    = 6'(FORCE_PWM_CYC);
            end
        end else if (slew_tick_i) begin
            if (blank_r != 6'h00) blank_nxt = blank_r - 6'h01;
            if (fpwm_r != 6'h00) fpwm_nxt = fpwm_r - 6'h01;
            else susp_mv_nxt = 1'b0;
        end

        case (st_r)
            ST_BOOT: begin
                if (system_power_good_in_i && !moving) begin
                    st_nxt  = ST_WAIT;
                    tmr_nxt = TMR_W'(SYSOK_CYC);
                end
            end
            ST_WAIT: begin
                if (!system_power_good_in_i || !fb_at_target_i) begin
                    st_nxt = ST_BOOT;
                end else if (tmr_r == '0 || tmr_r == TMR_W'(1)) begin
                    st_nxt     = ST_CKEN;
                    cken_n_nxt = 1'b0;
                    tmr_nxt    = TMR_W'(PGOOD_CYC);
                end else begin
                    tmr_nxt = tmr_r - TMR_W'(1);
                end
            end
            ST_CKEN: begin
                // keep enable low here so a freeze at entry cannot drop it
                if (!flt_r.over_v) begin
                    cken_n_nxt = 1'b0;
                end
                if (tmr_r != '0) begin
                    tmr_nxt = tmr_r - TMR_W'(1);
                end else if (!blanked && flt_r == '0) begin
                    pg_nxt = 1'b1;
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: ;
            default: st_nxt = ST_BOOT;
        endcase

        // detections gated by test mode and undervoltage blanking
        if (fault_det_i.over_v && !bypass) flt_nxt.over_v = 1'b1;
        if (fault_det_i.under_v && !bypass && !blanked)
            flt_nxt.under_v = 1'b1;
        if (fault_det_i.over_temp && !bypass)
            flt_nxt.over_temp = 1'b1;
        if (bypass) flt_nxt = '0;

        if (flt_nxt.over_v) begin
            pg_nxt     = 1'b0;
            cken_n_nxt = 1'b1;
        end
        if (flt_nxt.under_v || flt_nxt.over_temp) pg_nxt = 1'b0;

        // shutdown clears latches, counters and sequence
        if (restart) begin
            st_nxt      = ST_BOOT;
            tmr_nxt     = '0;
            blank_nxt   = 6'h00;
            fpwm_nxt    = 6'h00;
            susp_mv_nxt = 1'b0;
            flt_nxt     = '0;
            pg_nxt      = 1'b0;
            cken_n_nxt  = 1'b1;
        end
    end

    always_comb begin
        drv_nxt.pwm_enable = shutdown_n_i && (flt_r == '0);
        drv_nxt.force_pwm  = susp_mv_r;
        drv_nxt.low_side   = !shutdown_n_i || flt_r.over_v
                             || flt_r.over_temp;
        drv_nxt.high_side  = 1'b0;
        // undervoltage alone turns both gates off; a harder fault keeps low
        if (flt_r.under_v && !flt_r.over_v && !flt_r.over_temp) begin
            drv_nxt.low_side = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r      <= ST_BOOT;
            tmr_r     <= '0;
            blank_r   <= 6'h00;
            fpwm_r    <= 6'h00;
            susp_mv_r <= 1'b0;
            flt_r     <= '0;
            pg_r      <= 1'b0;
            cken_n_r  <= 1'b1;
            drv_r     <= '0;
            dac_r     <= CODE_RST;
            tr_r      <= 1'b0;
        end else begin
            st_r      <= st_nxt;
            tmr_r     <= tmr_nxt;
            blank_r   <= blank_nxt;
            fpwm_r    <= fpwm_nxt;
            susp_mv_r <= susp_mv_nxt;
            flt_r     <= flt_nxt;
            // frozen while blanked, but overvoltage and shutdown always get through
            if (!blanked || flt_nxt.over_v || restart) begin
                pg_r     <= pg_nxt;
                cken_n_r <= cken_n_nxt;
            end
            drv_r     <= drv_nxt;
            dac_r     <= code;
            tr_r      <= blanked;
        end
    end

    assign dac_code_o            = dac_r;
    assign drive_o               = drv_r;
    assign core_power_good_out_o = pg_r;
    assign clock_gen_enable_n_o  = cken_n_r;
    assign fault_latch_o         = flt_r;
    assign transition_o          = tr_r;
endmodule // cvs_core
`default_nettype wire

// ==== inc/cvs_pkg.sv ====
package cvs_pkg;
    localparam int CODE_W = 6;
    localparam int PIN4_W = 2;
    // four-level pin states
    localparam logic [1:0] LVL_GND  = 2'h0;
    localparam logic [1:0] LVL_REF  = 2'h1;
    localparam logic [1:0] LVL_OPEN = 2'h2;
    localparam logic [1:0] LVL_SUP  = 2'h3;
    // suspend table sits 16 codes below the cpu code scale
    localparam logic [6:0] SUSP_CODE_OFS = 7'h10;
    localparam logic [5:0] CODE_MAX = 6'h3F;
    localparam logic [5:0] CODE_RST = 6'h3F;
    localparam int FORCE_PWM_CYC = 62;
    localparam int BLANK_CYC = 32;
    localparam int FALL_SYNC_CYC = 2;
    localparam int SLEW_CNT_W = 7;
    // system clock and ms/us timers
    localparam int CLK_HZ = 40_000_000;
    localparam int SYSOK_DLY_US = 50;
    localparam int SYSOK_DLY_CYC = SYSOK_DLY_US * (CLK_HZ / 1_000_000);
    localparam int PGOOD_DLY_MS = 3;
    localparam int PGOOD_DLY_CYC = PGOOD_DLY_MS * (CLK_HZ / 1_000);
    localparam int TMR_W = 18;

    typedef struct packed {
        logic over_v;
        logic under_v;
        logic over_temp;
    } cvs_fault_t;

    typedef struct packed {
        logic low_side;
        logic high_side;
        logic pwm_enable;
        logic force_pwm;
    } cvs_drive_t;
endpackage

// ==== hw/cvs_slew.sv ====
`default_nettype none
module cvs_slew
    import cvs_pkg::*;
(
    input  wire logic              sys_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              restart_i,
    input  wire logic              slew_tick_i,
    input  wire logic [CODE_W-1:0] target_i,
    output logic      [CODE_W-1:0] code_o,
    output logic                   moving_o,
    output logic                   landed_o
);
    // larger code means lower voltage; a fall adds sync cycles
    logic [CODE_W-1:0] code_r, code_nxt;
    logic [1:0]        sync_r, sync_nxt;
    logic              moving_r, moving_nxt;
    logic              landed_r, landed_nxt;

    always_comb begin
        code_nxt   = code_r;
        sync_nxt   = sync_r;
        moving_nxt = moving_r;
        landed_nxt = 1'b0;
        if (target_i != code_r) begin
            if (!moving_r) begin
                moving_nxt = 1'b1;
                sync_nxt   = (target_i > code_r) ? 2'(FALL_SYNC_CYC)
                                                 : 2'h0;
            end else if (slew_tick_i) begin
                if (sync_r != 2'h0) begin
                    sync_nxt = sync_r - 2'h1;
                end else if (target_i > code_r) begin
                    code_nxt = code_r + 6'h01;
                end else begin
                    code_nxt = code_r - 6'h01;
                end
            end
        end else if (moving_r) begin
            moving_nxt = 1'b0;
            landed_nxt = 1'b1;
        end
        if (restart_i) begin
            code_nxt   = target_i;
            moving_nxt = 1'b0;
            sync_nxt   = 2'h0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_r   <= CODE_RST;
            sync_r   <= 2'h0;
            moving_r <= 1'b0;
            landed_r <= 1'b0;
        end else begin
            code_r   <= code_nxt;
            sync_r   <= sync_nxt;
            moving_r <= moving_nxt;
            landed_r <= landed_nxt;
        end
    end

    assign code_o   = code_r;
    assign moving_o = moving_r;
    assign landed_o = landed_r;
endmodule // cvs_slew
`default_nettype wire

// ==== verif/cvs_core_sva.sv ====
`default_nettype none
module cvs_core_sva
    import cvs_pkg::*;
#(
    parameter int SYSOK_CYC = 5,
    parameter int PGOOD_CYC = 20
) (
    input wire logic              sys_clk_i,
    input wire logic              nrst_i,
    input wire logic              shutdown_n_i,
    input wire logic              test_hv_i,
    input wire logic              slew_tick_i,
    input wire logic [CODE_W-1:0] dac_code_o,
    input wire cvs_drive_t        drive_o,
    input wire logic              core_power_good_out_o,
    input wire logic              clock_gen_enable_n_o,
    input wire cvs_fault_t        fault_latch_o,
    input wire logic              transition_o
);
    logic [3:0] sd_hist_r;
    logic       sd_ok;
    // shutdown may reload the code, so steps are judged well clear of it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sd_hist_r <= 4'h0;
        end else begin
            sd_hist_r <= {sd_hist_r[2:0], shutdown_n_i};
        end
    end
    assign sd_ok = (&sd_hist_r) && shutdown_n_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    step_size_a: assert property (
        sd_ok && $changed(dac_code_o) |->
        (dac_code_o - $past(dac_code_o) == 6'h01) ||
        ($past(dac_code_o) - dac_code_o == 6'h01))
        else $error("code moved by more than one step");
    step_tick_a: assert property (
        sd_ok && $changed(dac_code_o) |-> $past(slew_tick_i, 2))
        else $error("code moved without a slew tick");
    freeze_hold_a: assert property (
        transition_o && $past(transition_o) && sd_ok &&
        !fault_latch_o.over_v && !$past(fault_latch_o.over_v) |->
        $stable(core_power_good_out_o) && $stable(clock_gen_enable_n_o))
        else $error("status output changed while frozen");
    uv_blank_a: assert property (
        transition_o && $past(transition_o) |-> !$rose(fault_latch_o.under_v))
        else $error("undervoltage latched while blanked");
    ovp_out_a: assert property (
        $rose(fault_latch_o.over_v) |->
        ##[0:1] (!core_power_good_out_o && clock_gen_enable_n_o))
        else $error("overvoltage left status outputs alone");
    ovp_low_a: assert property (
        fault_latch_o.over_v && $past(fault_latch_o.over_v) |->
        drive_o.low_side)
        else $error("low side not held after overvoltage");
    therm_drv_a: assert property (
        fault_latch_o.over_temp && $past(fault_latch_o.over_temp) |->
        drive_o.low_side && !drive_o.high_side)
        else $error("thermal fault drive wrong");
    test_clr_a: assert property (
        test_hv_i && $past(test_hv_i) |-> fault_latch_o == 3'h0)
        else $error("fault latched in test mode");
endmodule // cvs_core_sva

bind cvs_core cvs_core_sva #(.SYSOK_CYC(SYSOK_CYC), .PGOOD_CYC(PGOOD_CYC))
    cvs_core_sva_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .shutdown_n_i(shutdown_n_i), .test_hv_i(test_hv_i),
    .slew_tick_i(slew_tick_i), .dac_code_o(dac_code_o), .drive_o(drive_o),
    .core_power_good_out_o(core_power_good_out_o),
    .clock_gen_enable_n_o(clock_gen_enable_n_o),
    .fault_latch_o(fault_latch_o), .transition_o(transition_o));
`default_nettype wire

// ==== verif/cvs_sys_model.sv ====
`default_nettype none
module cvs_sys_model #(
    parameter int TICK_DIV = 4
) (
    input  wire logic       sys_clk_i,
    input  wire logic       pg_req_i,
    input  wire logic [5:0] dac_code_i,
    input  wire logic [5:0] boot_code_i,
    output logic            slew_tick_o,
    output logic            system_power_good_in_o,
    output logic            fb_at_target_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int   div_q = 0;
    logic tick_q = 1'b0;
    logic pg_q = 1'b0;
    logic fb_q = 1'b0;
    // timing resistor clock runs free, one pulse every TICK_DIV cycles
    always @(negedge sys_clk_i) begin
        div_q <= (div_q + 1) % TICK_DIV;
        tick_q <= (div_q == 0);
        pg_q <= pg_req_i;
        fb_q <= (dac_code_i == boot_code_i);
    end
    assign slew_tick_o = tick_q;
    assign system_power_good_in_o = pg_q;
    assign fb_at_target_o = fb_q;
endmodule // cvs_sys_model
`default_nettype wire

// ==== verif/test_core_vid_slew_fault_sequencer.sv ====
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_core_vid_slew_fault_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import cvs_pkg::*;
    logic       sys_clk_i = 1'b0, nrst_i = 1'b0, shutdown_n_i = 1'b1;
    logic       test_hv_i = 1'b0, suspend_select = 1'b0, pg_req = 1'b0;
    logic [5:0] boot_pins = {LVL_REF, LVL_GND, LVL_GND};
    logic [5:0] susp_pins = {LVL_GND, LVL_OPEN, LVL_REF};
    logic [5:0] cpu_pins = 6'h20;
    cvs_fault_t fdet = 3'h0;
    wire logic  tick, sys_pg, fb_ok;
    logic [5:0] dac;
    cvs_drive_t drv;
    cvs_fault_t flt;
    logic       pg, cken_n, trans;
    int         n_errors = 0, checks_done = 0, n_cyc;
    cvs_core #(.SYSOK_CYC(5), .PGOOD_CYC(20)) cvs_core_inst (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .shutdown_n_i(shutdown_n_i),
        .test_hv_i(test_hv_i), .slew_tick_i(tick),
        .boot_code_pins_i(boot_pins), .suspend_code_pins_i(susp_pins),
        .cpu_voltage_code_pins_i(cpu_pins), .suspend_select_i(suspend_select),
        .system_power_good_in_i(sys_pg), .fb_at_target_i(fb_ok),
        .fault_det_i(fdet), .dac_code_o(dac), .drive_o(drv),
        .core_power_good_out_o(pg), .clock_gen_enable_n_o(cken_n),
        .fault_latch_o(flt), .transition_o(trans));
    cvs_sys_model cvs_sys_model_inst (.sys_clk_i(sys_clk_i),
        .pg_req_i(pg_req), .dac_code_i(dac), .boot_code_i(6'h10),
        .slew_tick_o(tick), .system_power_good_in_o(sys_pg),
        .fb_at_target_o(fb_ok));
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    function automatic logic [5:0] probe(input int sel);
        case (sel)
            0: return dac;
            1: return {5'h00, pg};
            2: return {5'h00, cken_n};
            3: return {5'h00, drv.force_pwm};
            default: return {5'h00, trans};
        endcase
    endfunction
    task automatic step(input int k);
        repeat (k) @(negedge sys_clk_i);
    endtask
    // bounded wait, n_cyc keeps how long the output took
    task automatic wait_for(input int sel, input logic [5:0] e);
        n_cyc = 0;
        while (probe(sel) !== e && n_cyc < 3000) begin
            step(1);
            n_cyc++;
        end
        `CHK(probe(sel), e)
    endtask
    task automatic sd_pulse;
        shutdown_n_i = 1'b0;
        step(2);
        shutdown_n_i = 1'b1;
        step(1);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #(40_000 * 25);
        n_errors++;
        complete_run;
    end
    initial begin
        step(10);
        nrst_i = 1'b1;
        `CHK(dac, CODE_RST)
        `CHK(cken_n, 1'b1)
        wait_for(0, 6'h10);
        wait_for(4, 6'h00);
        `CHK(cken_n, 1'b1)
        $display("test boot done");
        pg_req = 1'b1;
        wait_for(2, 6'h00);
        wait_for(0, 6'h20);
        wait_for(1, 6'h01);
        $display("test power good done");
        cpu_pins = 6'h22;
        wait_for(0, 6'h22);
        `CHK(n_cyc inside {[11:22]}, 1'b1)
        cpu_pins = 6'h21;
        wait_for(0, 6'h21);
        `CHK(n_cyc inside {[1:7]}, 1'b1)
        $display("test slew done");
        suspend_select = 1'b1;
        wait_for(3, 6'h01);
        wait_for(0, 6'h19);
        step(200);
        `CHK(drv.force_pwm, 1'b1)
        wait_for(3, 6'h00);
        `CHK(n_cyc inside {[30:70]}, 1'b1)
        suspend_select = 1'b0;
        wait_for(0, 6'h21);
        wait_for(4, 6'h00);
        $display("test suspend done");
        cpu_pins = 6'h25;
        step(2);
        fdet.under_v = 1'b1;
        step(4);
        fdet = 3'h0;
        `CHK(flt.under_v, 1'b0)
        wait_for(4, 6'h00);
        fdet.under_v = 1'b1;
        step(3);
        fdet = 3'h0;
        `CHK(flt.under_v, 1'b1)
        `CHK(drv.pwm_enable, 1'b0)
        sd_pulse;
        `CHK(flt, 3'h0)
        wait_for(1, 6'h01);
        $display("test undervoltage done");
        fdet.over_v = 1'b1;
        step(2);
        fdet = 3'h0;
        `CHK(pg, 1'b0)
        `CHK(cken_n, 1'b1)
        step(10);
        `CHK(flt.over_v, 1'b1)
        `CHK(drv.low_side, 1'b1)
        test_hv_i = 1'b1;
        step(3);
        `CHK(flt, 3'h0)
        fdet.over_temp = 1'b1;
        step(3);
        `CHK(flt, 3'h0)
        fdet = 3'h0;
        test_hv_i = 1'b0;
        step(2);
        $display("test overvoltage done");
        fdet.over_temp = 1'b1;
        step(3);
        `CHK(drv.low_side, 1'b1)
        `CHK(drv.high_side, 1'b0)
        fdet = 3'h0;
        sd_pulse;
        `CHK(flt, 3'h0)
        $display("test thermal done");
        complete_run;
    end
endmodule // test_core_vid_slew_fault_sequencer
`default_nettype wire
